// *** rtl/ppgd_top.sv ***
`timescale 1ns/10ps
`include "ppgd_regs.svh"
module ppgd_top
  import ppgd_pkg::*;
#(
  parameter bit SOFT_START = 1'b1,
  parameter bit HIGH_FREQ = 1'b1,
  parameter int SYNC_LOSS_CYC = `PPGD_SYNC_LOSS_CYC,
  parameter int RAMP_CYC = `PPGD_RAMP_CYC,
  parameter int PWRUP_CYC = `PPGD_PWRUP_CYC
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic supply_good,
  input wire logic enable,
  input wire logic sync_clk,
  output ppgd_pair_s gate_on,
  output ppgd_pair_s drain_oe,
  output ppgd_level_t drive_level,
  output logic full_drive,
  output logic ext_active,
  output logic dither_en
);
  localparam int DEAD_CYC = HIGH_FREQ ? `PPGD_DEAD_HF_CYC : `PPGD_DEAD_LF_CYC;
  localparam int INT_HALF = HIGH_FREQ ? `PPGD_INT_HALF_HF : `PPGD_INT_HALF_LF;
  localparam int STEP_CYC = RAMP_CYC / `PPGD_RAMP_STEPS;

  function automatic logic agree(input logic [2:0] s);
    agree = s[1] & s[2];
  endfunction

  // Three-stage synchronisers for pins
  logic [2:0] en_s_q, en_s_d, sy_s_q, sy_s_d, pg_s_q, pg_s_d;
  logic en_f_q, en_f_d, sy_f_q, sy_f_d, pg_f_q, pg_f_d;
  always_comb
  begin
    en_s_d = {en_s_q[1:0], enable};
    sy_s_d = {sy_s_q[1:0], sync_clk};
    pg_s_d = {pg_s_q[1:0], supply_good};
    en_f_d = (en_s_q[1] == en_s_q[2]) ? en_s_q[2] : en_f_q;
    sy_f_d = (sy_s_q[1] == sy_s_q[2]) ? sy_s_q[2] : sy_f_q;
    pg_f_d = (pg_s_q[1] == pg_s_q[2]) ? pg_s_q[2] : pg_f_q;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      en_s_q <= 3'h0;
      sy_s_q <= 3'h0;
      pg_s_q <= 3'h0;
      en_f_q <= 1'b0;
      sy_f_q <= 1'b0;
      pg_f_q <= 1'b0;
    end
    else
    begin
      en_s_q <= en_s_d;
      sy_s_q <= sy_s_d;
      pg_s_q <= pg_s_d;
      en_f_q <= en_f_d;
      sy_f_q <= sy_f_d;
      pg_f_q <= pg_f_d;
    end
  end

  logic run;
  logic sy_rise, en_rise;
  assign run = en_f_q & pg_f_q; // RULE11
  assign sy_rise = agree(sy_s_q) & ~sy_f_q;
  assign en_rise = en_f_d & ~en_f_q;

  // Sync-loss watchdog, internal oscillator and source select
  logic [15:0] loss_q, loss_d, osc_q, osc_d;
  logic ext_q, ext_d, tick;
  always_comb
  begin
    loss_d = loss_q;
    ext_d = ext_q;
    osc_d = osc_q;
    if (sy_rise)
    begin
      loss_d = 16'h0000; // RULE15
      ext_d = 1'b1;
    end
    else if (loss_q >= 16'(SYNC_LOSS_CYC - 1))
      ext_d = 1'b0; // RULE1
    else
      loss_d = loss_q + 16'h0001;
    if (osc_q >= 16'(INT_HALF - 1) || ext_q)
      osc_d = 16'h0000;
    else
      osc_d = osc_q + 16'h0001;
    // Tick source follows ext_q at once, so the half period running at a changeover can be cut short
    tick = ext_q ? sy_rise : (osc_q >= 16'(INT_HALF - 1)); // RULE12 RULE16
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      loss_q <= 16'h0000;
      ext_q <= 1'b0;
      osc_q <= 16'h0000;
    end
    else
    begin
      loss_q <= loss_d;
      ext_q <= ext_d;
      osc_q <= osc_d;
    end
  end
  assign ext_active = ext_q;
  assign dither_en = run & ~ext_q; // RULE13

  // Divide by two with dead time
  ppgd_state_e st_q, st_d;
  logic phase_q, phase_d;
  logic [7:0] dt_q, dt_d;
  ppgd_pair_s gate_q, gate_d;
  always_comb
  begin
    st_d = st_q;
    phase_d = phase_q;
    dt_d = dt_q;
    gate_d = gate_q;
    if (!run)
    begin
      st_d = PPGD_OFF; // RULE6
      gate_d = '0;
    end
    else
    begin
      case (st_q)
        PPGD_OFF:
        begin
          st_d = PPGD_DEAD;
          dt_d = 8'h00;
          gate_d = '0;
        end
        PPGD_DEAD:
        begin
          gate_d = '0; // RULE3
          if (dt_q >= 8'(DEAD_CYC - 1))
          begin
            st_d = PPGD_ON;
            gate_d.a = ~phase_q; // RULE5
            gate_d.b = phase_q;
          end
          else
            dt_d = dt_q + 8'h01; // RULE2
        end
        PPGD_ON:
        begin
          if (tick)
          begin
            phase_d = ~phase_q; // RULE4
            gate_d = '0;
            dt_d = 8'h00;
            st_d = PPGD_DEAD;
          end
        end
        default:
        begin
          st_d = PPGD_OFF;
          gate_d = '0;
        end
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= PPGD_OFF;
      phase_q <= 1'b0;
      dt_q <= 8'h00;
      gate_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      phase_q <= phase_d;
      dt_q <= dt_d;
      gate_q <= gate_d;
    end
  end
  assign gate_on = gate_q;

  // Assertion helper: cycles for which both gates have been low
  logic [7:0] lowc_q, lowc_d;
  always_comb
  begin
    lowc_d = lowc_q;
    if (gate_q != '0)
      lowc_d = 8'h00;
    else if (lowc_q != 8'hFF)
      lowc_d = lowc_q + 8'h01;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      lowc_q <= 8'h00;
    else
      lowc_q <= lowc_d;
  end
  sequence s_gate_rise;
    $rose(gate_q.a) || $rose(gate_q.b);
  endsequence
  a_break_first: assert property (@(posedge clk) disable iff (!rstn) // RULE3
    s_gate_rise |-> lowc_q >= 8'(DEAD_CYC)) else $error("gate rose too soon");

  // Drive enable, tri-stated when stopped
  ppgd_pair_s oe_q, oe_d;
  always_comb
  begin
    oe_d.a = run; // RULE14
    oe_d.b = run;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      oe_q <= '0;
    else
      oe_q <= oe_d;
  end
  assign drain_oe = oe_q;

  // Drive amplitude: ramp or fixed power-up delay
  ppgd_level_t lvl_q, lvl_d;
  logic [23:0] rc_q, rc_d;
  logic full_q, full_d;
  always_comb
  begin
    lvl_d = lvl_q;
    rc_d = rc_q;
    full_d = full_q;
    if (!run || en_rise)
    begin
      lvl_d = 8'h00; // RULE8
      rc_d = 24'h000000;
      full_d = 1'b0;
    end
    else if (SOFT_START) // RULE9
    begin
      if (lvl_q != 8'hFF)
      begin
        if (rc_q >= 24'(STEP_CYC - 1))
        begin
          rc_d = 24'h000000;
          lvl_d = lvl_q + 8'h01; // RULE10
        end
        else
          rc_d = rc_q + 24'h000001;
      end
      full_d = (lvl_q == 8'hFF);
    end
    else
    begin
      if (rc_q >= 24'(PWRUP_CYC - 1))
      begin
        lvl_d = 8'hFF; // RULE7
        full_d = 1'b1;
      end
      else
        rc_d = rc_q + 24'h000001;
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lvl_q <= 8'h00;
      rc_q <= 24'h000000;
      full_q <= 1'b0;
    end
    else
    begin
      lvl_q <= lvl_d;
      rc_q <= rc_d;
      full_q <= full_d;
    end
  end
  assign drive_level = lvl_q;
  assign full_drive = full_q;

  a_no_overlap: assert property (@(posedge clk) disable iff (!rstn) // RULE3
    !(gate_q.a && gate_q.b)) else $error("both gates on");
  sequence s_gate_fall;
    $fell(gate_q.a) || $fell(gate_q.b);
  endsequence
  a_dead_time: assert property (@(posedge clk) disable iff (!rstn) // RULE2
    s_gate_fall |-> (gate_q == '0) [*4]) else $error("dead time short");
  a_alternate: assert property (@(posedge clk) disable iff (!rstn) // RULE5
    $fell(gate_q.a) && run |-> ##[1:8] gate_q.b) else $error("no alternation");
  a_disable_off: assert property (@(posedge clk) disable iff (!rstn) // RULE6
    !run |=> gate_q == '0 && drain_oe == '0) else $error("outputs not off");
  a_loss_fall: assert property (@(posedge clk) disable iff (!rstn) // RULE1
    ext_q && loss_q >= 16'(SYNC_LOSS_CYC - 1) && !sy_rise |=> !ext_q)
    else $error("no fallback");
  a_loss_restart: assert property (@(posedge clk) disable iff (!rstn) // RULE15
    sy_rise |=> loss_q == 16'h0000 && ext_q) else $error("watchdog not restarted");
  a_dither_off: assert property (@(posedge clk) disable iff (!rstn) // RULE13
    ext_q |-> !dither_en) else $error("dither on with sync");
  a_dither_sync: assert property (@(posedge clk) disable iff (!rstn) // RULE13
    sy_rise |=> !dither_en) else $error("dither on after sync edge");
  a_ramp_restart: assert property (@(posedge clk) disable iff (!rstn) // RULE8
    en_rise |=> lvl_q == 8'h00 && !full_q) else $error("ramp not restarted");
  a_ramp_mono: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    run && !en_rise && SOFT_START |=> lvl_q >= $past(lvl_q)) else $error("ramp fell");
endmodule

// *** inc/ppgd_regs.svh ***
// Summary of operation
// (RULE1) Fall back to internal clock after 10-25 us
// (RULE2) Dead time 115 ns or 90 ns
// (RULE3) Both phases low before either goes high
// (RULE4) Divide selected clock by two
// (RULE5) Two complementary alternating gate phases
// (RULE6) Outputs off within 5 us of disable
// (RULE7) No soft-start: full drive within 100 us
// (RULE8) Soft-start ramps drive on each enable rise
// (RULE9) Soft-start is a build-time option
// (RULE10) Ramp reaches 90 percent within 18 ms
// (RULE11) Switching starts once supply is good
// (RULE12) External clock divided on each rising edge
// (RULE13) Dither off while external clock valid
// (RULE14) Drains tri-stated when disabled or undervoltage
// (RULE15) Sync loss counter restarts on each rising edge
// (RULE16) Glitch-free source changeover keeps dead time
`ifndef PPGD_REGS_SVH
`define PPGD_REGS_SVH
`define PPGD_CLK_MHZ 40
`define PPGD_SYNC_LOSS_US 15
`define PPGD_SYNC_LOSS_CYC (`PPGD_SYNC_LOSS_US * `PPGD_CLK_MHZ)
`define PPGD_DEAD_LF_NS 115
`define PPGD_DEAD_HF_NS 90
`define PPGD_DEAD_LF_CYC ((`PPGD_DEAD_LF_NS * `PPGD_CLK_MHZ + 999) / 1000)
`define PPGD_DEAD_HF_CYC ((`PPGD_DEAD_HF_NS * `PPGD_CLK_MHZ + 999) / 1000)
`define PPGD_INT_HALF_LF 125
`define PPGD_INT_HALF_HF 48
`define PPGD_RAMP_MS 8
`define PPGD_RAMP_CYC (`PPGD_RAMP_MS * 1000 * `PPGD_CLK_MHZ)
`define PPGD_RAMP_STEPS 256
`define PPGD_PWRUP_US 50
`define PPGD_PWRUP_CYC (`PPGD_PWRUP_US * `PPGD_CLK_MHZ)
`endif

// *** inc/ppgd_pkg.sv ***
package ppgd_pkg;
  typedef enum logic [1:0] {
    PPGD_OFF = 2'b00,
    PPGD_DEAD = 2'b01,
    PPGD_ON = 2'b10
  } ppgd_state_e;
  typedef struct packed {
    logic a;
    logic b;
  } ppgd_pair_s;
  typedef logic [7:0] ppgd_level_t;
endpackage

// *** tb/ppgd_switch_model.sv ***
`timescale 1ns/10ps
module ppgd_switch_model
  import ppgd_pkg::*;
(
  input wire logic clk,
  input ppgd_pair_s gate_on,
  input ppgd_pair_s drain_oe,
  output int overlaps,
  output int undriven
);
  initial overlaps = 0;
  initial undriven = 0;
  // A switch gated on while its drain is released would conduct uncontrolled
  always @(negedge clk)
    if ((gate_on.a === 1'b1 && drain_oe.a !== 1'b1) || (gate_on.b === 1'b1 && drain_oe.b !== 1'b1))
      undriven++;
  // Both halves of the primary on at once would short the supply
  always @(negedge clk)
    if (gate_on.a === 1'b1 && gate_on.b === 1'b1)
      overlaps++;
endmodule

// *** tb/tb_push_pull_gate_drive_sequencer.sv ***
`timescale 1ns/10ps
`include "ppgd_regs.svh"
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("Error %0t: value mismatch", $time); \
    end \
  end
module tb_push_pull_gate_drive_sequencer
  import ppgd_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic supply_good = 1'b0;
  logic enable = 1'b0;
  logic sync_clk = 1'b0;
  logic sync_run = 1'b0;
  ppgd_pair_s gate_on;
  ppgd_pair_s drain_oe;
  ppgd_level_t drive_level;
  logic full_drive;
  logic ext_active;
  logic dither_en;
  int overlaps;
  int undriven;
  ppgd_pair_s lf_gate_on;
  ppgd_pair_s lf_drain_oe;
  ppgd_level_t lf_drive_level;
  logic lf_full_drive;
  logic lf_ext_active;
  logic lf_dither_en;
  int lf_overlaps;
  int lf_undriven;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int sdiv = 0;

  always #12.5 clk = ~clk;

  ppgd_top #(.SYNC_LOSS_CYC(40), .RAMP_CYC(512), .PWRUP_CYC(20)) dut (
    .clk(clk),
    .rstn(rstn),
    .supply_good(supply_good),
    .enable(enable),
    .sync_clk(sync_clk),
    .gate_on(gate_on),
    .drain_oe(drain_oe),
    .drive_level(drive_level),
    .full_drive(full_drive),
    .ext_active(ext_active),
    .dither_en(dither_en)
  );

  ppgd_switch_model sw (
    .clk(clk),
    .gate_on(gate_on),
    .drain_oe(drain_oe),
    .overlaps(overlaps),
    .undriven(undriven)
  );

  // Fast-start, low-frequency build on the same pins
  ppgd_top #(.SOFT_START(1'b0), .HIGH_FREQ(1'b0), .SYNC_LOSS_CYC(40), .PWRUP_CYC(20))
  dut_lf (
    .clk(clk),
    .rstn(rstn),
    .supply_good(supply_good),
    .enable(enable),
    .sync_clk(sync_clk),
    .gate_on(lf_gate_on),
    .drain_oe(lf_drain_oe),
    .drive_level(lf_drive_level),
    .full_drive(lf_full_drive),
    .ext_active(lf_ext_active),
    .dither_en(lf_dither_en)
  );

  ppgd_switch_model sw_lf (
    .clk(clk),
    .gate_on(lf_gate_on),
    .drain_oe(lf_drain_oe),
    .overlaps(lf_overlaps),
    .undriven(lf_undriven)
  );

  // Sync source: one rising edge every 20 cycles while running
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    sdiv <= (sdiv == 9) ? 0 : sdiv + 1;
    if (sync_run && sdiv == 9)
      sync_clk <= ~sync_clk;
  end

  always @(posedge clk)
    if (cyc == 20000)
    begin
      miscompares++;
      wrap_up();
    end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cycles until the next rising edge of phase a of either build
  task automatic wait_rise(input bit lf, output int n);
    n = 0;
    while ((lf ? lf_gate_on.a : gate_on.a) === 1'b1 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    while ((lf ? lf_gate_on.a : gate_on.a) !== 1'b1 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wait_for(ref logic sig, input logic val, input int lim);
    int n;
    n = 0;
    while (sig !== val && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic t_start();
    int n;
    int lo;
    @(posedge clk);
    supply_good <= 1'b1;
    enable <= 1'b1;
    wait_rise(1'b0, n);
    `CHK(n < 30, 1'b1)
    `CHK(drain_oe, 2'b11)
    // The first pulse is not aligned to the oscillator, so measure the next period
    wait_rise(1'b0, n);
    wait_rise(1'b0, n);
    `CHK(n, 2 * `PPGD_INT_HALF_HF)
    lo = 0;
    while (gate_on.b !== 1'b1 && lo < 500)
    begin
      @(negedge clk);
      if (gate_on === 2'b00)
        lo++;
    end
    `CHK(lo >= `PPGD_DEAD_HF_CYC, 1'b1)
    `CHK(gate_on, 2'b01)
    `CHK(overlaps, 0)
    $display("t_start done");
  endtask

  task automatic t_ramp();
    `CHK(dither_en, 1'b1)
    `CHK(drive_level !== 8'hFF, 1'b1)
    wait_for(full_drive, 1'b1, 700);
    `CHK(full_drive, 1'b1)
    `CHK(drive_level, 8'hFF)
    $display("t_ramp done");
  endtask

  task automatic t_ext();
    int n;
    @(posedge clk) sync_run <= 1'b1;
    wait_for(ext_active, 1'b1, 100);
    `CHK(ext_active, 1'b1)
    @(negedge clk);
    `CHK(dither_en, 1'b0)
    repeat (3) wait_rise(1'b0, n);
    `CHK(n, 40)
    @(posedge sync_clk);
    @(posedge clk) sync_run <= 1'b0;
    repeat (30) @(negedge clk);
    `CHK(ext_active, 1'b1)
    wait_for(ext_active, 1'b0, 30);
    `CHK(ext_active, 1'b0)
    `CHK(overlaps, 0)
    $display("t_ext done");
  endtask

  task automatic t_off();
    int n;
    @(posedge clk) enable <= 1'b0;
    repeat (200) @(negedge clk);
    `CHK(gate_on, 2'b00)
    `CHK(drain_oe, 2'b00)
    @(posedge clk) enable <= 1'b1;
    wait_rise(1'b0, n);
    `CHK(full_drive, 1'b0)
    `CHK(drive_level !== 8'hFF, 1'b1)
    @(posedge clk) supply_good <= 1'b0;
    repeat (10) @(negedge clk);
    `CHK(drain_oe, 2'b00)
    `CHK(undriven, 0)
    $display("t_off done");
  endtask

  task automatic t_fast();
    int n;
    int lo;
    int ramp;
    @(posedge clk) supply_good <= 1'b1;
    n = 0;
    ramp = 0;
    while (lf_full_drive !== 1'b1 && n < 100 * `PPGD_CLK_MHZ)
    begin
      if (lf_drive_level !== 8'h00)
        ramp++;
      @(negedge clk);
      n++;
    end
    `CHK(n < 100 * `PPGD_CLK_MHZ, 1'b1)
    `CHK(ramp, 0)
    `CHK(lf_drive_level, 8'hFF)
    `CHK(full_drive, 1'b0)
    `CHK(lf_drain_oe, 2'b11)
    `CHK(lf_dither_en, 1'b1)
    `CHK(lf_ext_active, 1'b0)
    repeat (3) wait_rise(1'b1, n);
    `CHK(n, 2 * `PPGD_INT_HALF_LF)
    lo = 0;
    while (lf_gate_on.b !== 1'b1 && lo < 500)
    begin
      @(negedge clk);
      if (lf_gate_on === 2'b00)
        lo++;
    end
    `CHK(lo, `PPGD_DEAD_LF_CYC)
    `CHK(lf_gate_on, 2'b01)
    `CHK(lf_overlaps, 0)
    `CHK(lf_undriven, 0)
    $display("t_fast done");
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_start();
    t_ramp();
    t_ext();
    t_off();
    t_fast();
    wrap_up();
  end
endmodule
